//--- core/phy_ctrl_pkg.sv
package phy_ctrl_pkg;

  // ----------------------------------------
  // Register location and field positions
  // ----------------------------------------
  localparam int REG_W = 16;
  localparam logic [4:0] REG_INDEX_BASIC_CONTROL = 5'h00;
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPEED = 13;
  localparam int BIT_AUTONEG = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COL_TEST = 7;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic RST_LOOPBACK = 1'h0;
  localparam logic RST_POWER_DOWN = 1'h0;
  localparam logic RST_COL_TEST = 1'h0;
  localparam logic FIBER_SPEED_DEFAULT = 1'h1;
  localparam logic FIBER_AUTONEG_DEFAULT = 1'h0;
  localparam logic [1:0] INIT_CYCLES = 2'h3;

  // ----------------------------------------
  // Management frame
  // ----------------------------------------
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [4:0] MDIO_HDR_LAST = 5'h0B;
  localparam logic [4:0] MDIO_DATA_LAST = 5'h0F;

  typedef enum logic [2:0] {
    MDIO_IDLE,
    MDIO_START,
    MDIO_HDR,
    MDIO_TA,
    MDIO_DATA
  } mdio_state_e;

  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
  } strap_s;

  typedef struct packed {
    logic loopback;
    logic speed;
    logic autoneg;
    logic power_down;
    logic duplex;
    logic col_test;
  } ctrl_fields_s;

  typedef struct packed {
    logic loopback;
    logic power_down;
    logic autoneg_enable;
    logic forced_speed_100;
    logic forced_full_duplex;
    logic collision_test;
  } ctrl_out_s;

  function automatic ctrl_fields_s default_fields(input strap_s s, input logic fiber);
    ctrl_fields_s f;
    f.loopback = RST_LOOPBACK;
    f.power_down = RST_POWER_DOWN;
    f.col_test = RST_COL_TEST;
    f.speed = fiber ? FIBER_SPEED_DEFAULT : (s.autoneg | s.speed);
    f.autoneg = fiber ? FIBER_AUTONEG_DEFAULT : s.autoneg;
    f.duplex = fiber ? s.duplex : (~s.autoneg & s.duplex);
    return f;
  endfunction

  function automatic logic [REG_W-1:0] read_word(input ctrl_fields_s f, input logic fiber);
    logic [REG_W-1:0] w;
    w = '0;
    w[BIT_LOOPBACK] = f.loopback;
    w[BIT_SPEED] = f.speed;
    w[BIT_AUTONEG] = f.autoneg & ~fiber;
    w[BIT_POWER_DOWN] = f.power_down;
    w[BIT_DUPLEX] = f.duplex;
    w[BIT_COL_TEST] = f.col_test;
    return w;
  endfunction

endpackage

//--- core/sync2.sv
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  always_comb begin
    next_state.meta = d_i;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q_o = state.stable;

endmodule

//--- core/phy_basic_control_reg.sv
`timescale 1ns/1ps

// Functional notes
// - Bit 15 restores defaults, then self-clears
// - Bit 14 loops transmit into receive
// - Bit 13 forces 10 or 100 Mbps
// - Bit 12 enables autoneg, overriding forced bits
// - Fiber mode forces autoneg enable to zero
// - Bit 11 selects general power down
// - Bit 9 restarts autoneg, self-clears
// - Bit 8 forces half or full duplex
// - Bit 7 asserts collision during transmission
// - Speed default is autoneg OR speed strap
// - Fiber mode speed default is one
// - Autoneg default is strap, zero in fiber
// - Copper duplex default: not autoneg AND duplex
// - Fiber duplex default is duplex strap only
// - Reachable by indirect pair and serial pins
// - Serial input sampled on management clock rise
module phy_basic_control_reg
  import phy_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire strap_s strap_i,
  input wire logic fiber_mode_select_i,
  input wire logic [4:0] phy_addr_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic acc_req_i,
  input wire logic acc_write_i,
  input wire logic [4:0] acc_index_i,
  input wire logic [REG_W-1:0] acc_wdata_i,
  output logic acc_done_o,
  output logic [REG_W-1:0] acc_rdata_o,
  output logic ready_o,
  input wire logic tx_active_i,
  output logic collision_o,
  output ctrl_out_s ctrl_o,
  output logic soft_reset_o,
  output logic autoneg_restart_o
);

  // ----------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------
  logic rst_n;
  logic mdc_s;
  logic mdio_s;
  logic fiber_s;
  strap_s strap_s_q;
  logic [4:0] phy_addr_s;

  sync2 #(.WIDTH(1)) u_rst_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .d_i(1'h1),
    .q_o(rst_n)
  );

  sync2 #(.WIDTH(11)) u_pin_sync (
    .clock_i(clock_i),
    .rstn_i(rst_n),
    .d_i({mdc_i, mdio_i, fiber_mode_select_i, strap_i, phy_addr_i}),
    .q_o({mdc_s, mdio_s, fiber_s, strap_s_q, phy_addr_s})
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] init_cnt;
    logic loaded;
    ctrl_fields_s fields;
    logic mdc_q;
    mdio_state_e mst;
    logic [4:0] bit_cnt;
    logic [REG_W-1:0] shreg;
    logic rd_op;
    logic hit;
    logic mdio_out;
    logic mdio_oe;
    logic acc_done;
    logic [REG_W-1:0] acc_rdata;
    logic collision;
    ctrl_out_s ctrl;
    logic soft_reset;
    logic an_restart;
  } state_s;

  state_s state;
  state_s next_state;

  always_comb begin
    logic mdc_rise;
    logic [REG_W-1:0] nsh;
    logic [REG_W-1:0] cur_word;
    logic wr_en;
    logic [REG_W-1:0] wr_data;
    logic acc_take;
    logic an_eff;
    mdc_rise = 1'h0;
    nsh = '0;
    cur_word = '0;
    wr_en = 1'h0;
    wr_data = '0;
    acc_take = 1'h0;
    an_eff = 1'h0;

    next_state = state;
    next_state.mdc_q = mdc_s;
    next_state.acc_done = 1'h0;
    next_state.soft_reset = 1'h0;
    next_state.an_restart = 1'h0;
    cur_word = read_word(state.fields, fiber_s);

    // Strap capture once synchronisers have settled
    if (!state.loaded) begin
      if (state.init_cnt == INIT_CYCLES) begin
        next_state.loaded = 1'h1;
        next_state.fields = default_fields(strap_s_q, fiber_s);
      end else begin
        next_state.init_cnt = state.init_cnt + 2'h1;
      end
    end

    // ----------------------------------------
    // Management serial slave
    // ----------------------------------------
    // sample on MDC rise
    mdc_rise = mdc_s & ~state.mdc_q;
    nsh = {state.shreg[REG_W-2:0], mdio_s};
    if (mdc_rise) begin
      case (state.mst)
        MDIO_IDLE: begin
          if (!mdio_s) begin
            next_state.mst = MDIO_START;
          end
        end
        MDIO_START: begin
          next_state.mst = mdio_s ? MDIO_HDR : MDIO_IDLE;
          next_state.bit_cnt = '0;
        end
        MDIO_HDR: begin
          next_state.shreg = nsh;
          next_state.bit_cnt = state.bit_cnt + 5'h01;
          if (state.bit_cnt == MDIO_HDR_LAST) begin
            next_state.bit_cnt = '0;
            next_state.rd_op = (nsh[11:10] == MDIO_OP_READ);
            next_state.hit = state.loaded && (nsh[9:5] == phy_addr_s)
                             && (nsh[4:0] == REG_INDEX_BASIC_CONTROL);
            if (nsh[11:10] == MDIO_OP_READ || nsh[11:10] == MDIO_OP_WRITE) begin
              next_state.mst = MDIO_TA;
            end else begin
              next_state.mst = MDIO_IDLE;
            end
          end
        end
        MDIO_TA: begin
          if (state.bit_cnt == '0) begin
            next_state.bit_cnt = 5'h01;
            if (state.rd_op && state.hit) begin
              // Drive turnaround zero, snapshot register
              next_state.mdio_oe = 1'h1;
              next_state.mdio_out = 1'h0;
              next_state.shreg = cur_word;
            end
          end else begin
            next_state.bit_cnt = '0;
            next_state.mst = MDIO_DATA;
            if (state.rd_op && state.hit) begin
              next_state.mdio_out = state.shreg[REG_W-1];
              next_state.shreg = {state.shreg[REG_W-2:0], 1'h0};
            end
          end
        end
        MDIO_DATA: begin
          next_state.bit_cnt = state.bit_cnt + 5'h01;
          if (state.rd_op) begin
            next_state.mdio_out = state.shreg[REG_W-1];
            next_state.shreg = {state.shreg[REG_W-2:0], 1'h0};
          end else begin
            next_state.shreg = nsh;
          end
          if (state.bit_cnt == MDIO_DATA_LAST) begin
            next_state.mst = MDIO_IDLE;
            next_state.mdio_oe = 1'h0;
            next_state.mdio_out = 1'h0;
            if (!state.rd_op && state.hit) begin
              wr_en = 1'h1;
              wr_data = nsh;
            end
          end
        end
        default: begin
          next_state.mst = MDIO_IDLE;
          next_state.mdio_oe = 1'h0;
        end
      endcase
    end

    // ----------------------------------------
    // Indirect access port
    // ----------------------------------------
    // serial write wins, indirect waits
    acc_take = acc_req_i && state.loaded && !state.acc_done && !wr_en;
    if (acc_take) begin
      next_state.acc_done = 1'h1;
      next_state.acc_rdata = (acc_index_i == REG_INDEX_BASIC_CONTROL) ? cur_word : '0;
      if (acc_write_i && acc_index_i == REG_INDEX_BASIC_CONTROL) begin
        wr_en = 1'h1;
        wr_data = acc_wdata_i;
      end
    end

    // ----------------------------------------
    // Register write
    // ----------------------------------------
    if (wr_en) begin
      if (wr_data[BIT_SOFT_RESET]) begin
        next_state.fields = default_fields(strap_s_q, fiber_s);
        next_state.soft_reset = 1'h1;
      end else begin
        next_state.fields.loopback = wr_data[BIT_LOOPBACK];
        next_state.fields.speed = wr_data[BIT_SPEED];
        next_state.fields.autoneg = wr_data[BIT_AUTONEG];
        next_state.fields.power_down = wr_data[BIT_POWER_DOWN];
        next_state.fields.duplex = wr_data[BIT_DUPLEX];
        next_state.fields.col_test = wr_data[BIT_COL_TEST];
        next_state.an_restart = wr_data[BIT_AN_RESTART];
      end
    end

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    // fiber forces autoneg off
    an_eff = next_state.fields.autoneg & ~fiber_s;
    next_state.ctrl.loopback = next_state.fields.loopback;
    next_state.ctrl.power_down = next_state.fields.power_down;
    next_state.ctrl.autoneg_enable = an_eff;
    next_state.ctrl.forced_speed_100 = next_state.fields.speed & ~an_eff;
    next_state.ctrl.forced_full_duplex = next_state.fields.duplex & ~an_eff;
    next_state.ctrl.collision_test = next_state.fields.col_test;
    next_state.collision = state.fields.col_test & tx_active_i;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.mst <= MDIO_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign mdio_o = state.mdio_out;
  assign mdio_oe_o = state.mdio_oe;
  assign acc_done_o = state.acc_done;
  assign acc_rdata_o = state.acc_rdata;
  assign ready_o = state.loaded;
  assign collision_o = state.collision;
  assign ctrl_o = state.ctrl;
  assign soft_reset_o = state.soft_reset;
  assign autoneg_restart_o = state.an_restart;

endmodule

//--- bench/phy_ctrl_checker.sv
`timescale 1ns/1ps

module phy_ctrl_checker
  import phy_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic fiber_mode_select_i,
  input wire logic acc_req_i,
  input wire logic acc_done_o,
  input wire logic [REG_W-1:0] acc_rdata_o,
  input wire logic ready_o,
  input wire logic tx_active_i,
  input wire logic collision_o,
  input wire ctrl_out_s ctrl_o,
  input wire logic soft_reset_o,
  input wire logic autoneg_restart_o,
  input wire logic mdio_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_srst_defaults: assert property (soft_reset_o |-> !ctrl_o.loopback && !ctrl_o.power_down)
    else $error("soft reset left modes set");
  a_srst_single: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  a_restart_single: assert property (autoneg_restart_o |=> !autoneg_restart_o)
    else $error("restart pulse too long");
  a_fiber_an_off: assert property (fiber_mode_select_i [*4] |-> !ctrl_o.autoneg_enable)
    else $error("autoneg active in fiber mode");
  a_an_overrides: assert property (ctrl_o.autoneg_enable |-> !ctrl_o.forced_speed_100 && !ctrl_o.forced_full_duplex)
    else $error("forced bits active with autoneg");
  a_col_on: assert property (tx_active_i && ctrl_o.collision_test |=> collision_o)
    else $error("collision missing in test mode");
  a_col_off: assert property (!tx_active_i |=> !collision_o)
    else $error("collision without transmit");
  a_idle_quiet: assert property (!ready_o |-> !mdio_oe_o && !acc_done_o)
    else $error("activity before ready");
  a_rsvd_zero: assert property (acc_done_o |-> acc_rdata_o[10] == 1'h0 && acc_rdata_o[6:0] == 7'h00)
    else $error("reserved bits read nonzero");
  a_done_bounded: assert property (acc_req_i && ready_o && !acc_done_o |-> ##[1:2] acc_done_o)
    else $error("indirect access not answered");

  c_srst: cover property (soft_reset_o);
  c_restart: cover property (autoneg_restart_o);
  c_serial_rd: cover property (mdio_oe_o);
  c_col: cover property (collision_o);
endmodule

bind phy_basic_control_reg phy_ctrl_checker phy_ctrl_checker_inst (.clock_i(clock_i), .rstn_i(rstn_i),
  .fiber_mode_select_i(fiber_mode_select_i), .acc_req_i(acc_req_i), .acc_done_o(acc_done_o),
  .acc_rdata_o(acc_rdata_o), .ready_o(ready_o), .tx_active_i(tx_active_i), .collision_o(collision_o),
  .ctrl_o(ctrl_o), .soft_reset_o(soft_reset_o), .autoneg_restart_o(autoneg_restart_o), .mdio_oe_o(mdio_oe_o));

//--- bench/mdio_master.sv
`timescale 1ns/1ps

module mdio_master (
  input wire logic clock_i,
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  initial begin
    mdc_o = 1'h0;
    mdio_o = 1'h1;
    mdio_oe_o = 1'h0;
  end

  // ----------------------------------------
  // Frame, MDC held low between frames
  // ----------------------------------------
  // zeroed register address, data set on MDC fall
  task automatic frame(input logic [1:0] op, input logic [4:0] ad, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] f;
    f = {2'h1, op, ad, 5'h00, 2'h2, d};
    q = '0;
    for (int i = -4; i < 32; i++) begin
      @(negedge clock_i);
      mdc_o = 1'h0;
      mdio_oe_o = (i < 14) || (op == 2'h1);
      mdio_o = (i < 0) ? 1'h1 : f[31 - i];
      repeat (4) @(negedge clock_i);
      mdc_o = 1'h1;
      if (i >= 16) q = {q[14:0], mdio_i};
      repeat (3) @(negedge clock_i);
    end
    mdc_o = 1'h0;
    mdio_oe_o = 1'h0;
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps

module testbench;
  import phy_ctrl_pkg::*;
  logic clock_i = 0, rstn_i = 0, fiber = 0, req = 0, wr = 0, tx = 0;
  strap_s strap = '0;
  logic [4:0] idx = '0;
  logic [15:0] wd = '0, rd, q;
  logic [1:0] pl;
  logic done, ready, mo, moe, srst, anr, col, mdc, m_o, m_oe, line;
  ctrl_out_s ctrl;
  int error_cnt = 0, total_checks = 0;

  always #25 clock_i = ~clock_i;
  // Pull-up on the shared management line
  assign line = moe ? mo : (m_oe ? m_o : 1'h1);

  phy_basic_control_reg phy_basic_control_reg_inst (.clock_i(clock_i), .rstn_i(rstn_i), .strap_i(strap),
    .fiber_mode_select_i(fiber), .phy_addr_i(5'h05), .mdc_i(mdc), .mdio_i(line), .mdio_o(mo), .mdio_oe_o(moe),
    .acc_req_i(req), .acc_write_i(wr), .acc_index_i(idx), .acc_wdata_i(wd), .acc_done_o(done),
    .acc_rdata_o(rd), .ready_o(ready), .tx_active_i(tx), .collision_o(col), .ctrl_o(ctrl),
    .soft_reset_o(srst), .autoneg_restart_o(anr));
  mdio_master mdio_master_inst (.clock_i(clock_i), .mdio_i(line), .mdc_o(mdc), .mdio_o(m_o), .mdio_oe_o(m_oe));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic acc(logic w, logic [4:0] i, logic [15:0] d);
    int n;
    @(negedge clock_i);
    req = 1;
    wr = w;
    idx = i;
    wd = d;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (done !== 1'h1 && n < 20);
    chk("done", 16'h0001, {15'h0, done});
    pl = {srst, anr};
    req = 0;
  endtask

  task automatic rst(strap_s s, logic f);
    int n;
    @(negedge clock_i);
    rstn_i = 0;
    strap = s;
    fiber = f;
    repeat (10) @(negedge clock_i);
    rstn_i = 1;
    n = 0;
    while (ready !== 1'h1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    chk("ready", 16'h0001, {15'h0, ready});
  endtask

  function automatic logic [15:0] dflt(strap_s s, logic f);
    return {2'h0, f | s.autoneg | s.speed, ~f & s.autoneg, 3'h0, f ? s.duplex : ~s.autoneg & s.duplex, 8'h00};
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 16; k++) begin
      rst(strap_s'(k[2:0]), k[3]);
      acc(0, 5'h00, 16'h0000);
      chk("default", dflt(strap_s'(k[2:0]), k[3]), rd);
    end
    rst(3'h0, 1'h0);
    acc(1, 5'h00, 16'h5FFF);
    chk("pulses", 16'h0001, {14'h0, pl});
    chk("ctrl", 16'h0039, {10'h0, ctrl});
    acc(0, 5'h00, 16'h0000);
    chk("readback", 16'h5980, rd);
    tx = 1;
    repeat (2) @(negedge clock_i);
    chk("collision", 16'h0001, {15'h0, col});
    tx = 0;
    repeat (2) @(negedge clock_i);
    chk("collision", 16'h0000, {15'h0, col});
    acc(1, 5'h00, 16'h2100);
    chk("ctrl", 16'h0006, {10'h0, ctrl});
    acc(1, 5'h00, 16'h0000);
    chk("ctrl", 16'h0000, {10'h0, ctrl});
    fiber = 1;
    repeat (4) @(negedge clock_i);
    acc(1, 5'h00, 16'h1000);
    acc(0, 5'h00, 16'h0000);
    chk("fiber read", 16'h0000, rd);
    chk("fiber ctrl", 16'h0000, {10'h0, ctrl});
    fiber = 0;
    // Let the fiber synchroniser settle before the soft reset
    repeat (4) @(negedge clock_i);
    acc(1, 5'h00, 16'hC800);
    chk("pulses", 16'h0002, {14'h0, pl});
    acc(0, 5'h00, 16'h0000);
    chk("after srst", 16'h0000, rd);
    acc(0, 5'h03, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    mdio_master_inst.frame(2'h1, 5'h05, 16'h4100, q);
    mdio_master_inst.frame(2'h1, 5'h06, 16'h0800, q);
    repeat (8) @(negedge clock_i);
    acc(0, 5'h00, 16'h0000);
    chk("serial write", 16'h4100, rd);
    mdio_master_inst.frame(2'h2, 5'h05, 16'h0000, q);
    chk("serial read", 16'h4100, q);
    test_done();
  end

  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
endmodule
